// >>> dltc_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DLTC_REGS_SVH
`define DLTC_REGS_SVH

// ********************
// Register offsets
// ********************
`define DLTC_OFS_CTRL            5'h00
`define DLTC_OFS_CFG0            5'h04
`define DLTC_OFS_CFG1            5'h08
`define DLTC_OFS_STATUS          5'h0C
`define DLTC_OFS_CFG2            5'h10

// ********************
// Control bits (write one to start)
// ********************
`define DLTC_CTRL_GEAR           0
`define DLTC_CTRL_LEVEL          1
`define DLTC_CTRL_TERM           2
`define DLTC_CTRL_REFRESH        3

// ********************
// Configuration fields
// ********************
`define DLTC_CFG1_PRE2           16
`define DLTC_CFG1_PAR_EN         17
`define DLTC_CFG1_DLL_OFF        18
`define DLTC_CFG0_RST            32'h0018_0000
`define DLTC_CFG1_RST            32'h0000_0100
`define DLTC_CFG2_RST            32'h0000_0100

// ********************
// Timing counts in link clock cycles, times in ps and the slow-grade transfer rate
// ********************
`define DLTC_TERM_HIGH_MIN_SHORT 16'h0004
`define DLTC_TERM_HIGH_MIN_LONG  16'h0005
`define DLTC_LEVEL_FIRST_STROBE  16'h0028
`define DLTC_LEVEL_STROBE_EN     16'h0019
`define DLTC_LEVEL_FEEDBACK_PS   9500
`define DLTC_SYNC_EXTRA          16'h0004
`define DLTC_SYNC_SETUP          16'h0002
`define DLTC_SYNC_HOLD           16'h0002
`define DLTC_SEL_CMD_MIN         3
`define DLTC_SEL_CMD_PS          3748
`define DLTC_MCLK_PS             10000
`define DLTC_SLOW_RATE           1600

`endif

// >>> dltc_pkg.sv
// Types and clock conversion functions of the leveling and gear-down sequencer
package dltc_pkg;

    typedef enum logic [3:0] {
        DLTC_IDLE  = 4'h0,
        DLTC_RST   = 4'h1,
        DLTC_GSYNW = 4'h2,
        DLTC_GSET  = 4'h3,
        DLTC_GHOLD = 4'h4,
        DLTC_GCMDW = 4'h5,
        DLTC_GCAL  = 4'h6,
        DLTC_WENW  = 4'h7,
        DLTC_WEDGE = 4'h8,
        DLTC_WSAMP = 4'h9,
        DLTC_TERM  = 4'hA,
        DLTC_REF   = 4'hB
    } dltc_state_t;

    typedef enum logic [2:0] {
        DLTC_CMD_NOP   = 3'h0,
        DLTC_CMD_MRS   = 3'h1,
        DLTC_CMD_REF   = 3'h2,
        DLTC_CMD_SYNC  = 3'h3,
        DLTC_CMD_VALID = 3'h4
    } dltc_cmd_t;

    // Table-parameter rounding: truncate(ps/tck + 0.974)
    function automatic int dltc_round_spd(input int ps, input int tck_ps);
        dltc_round_spd = (ps * 1000 + 974 * tck_ps) / (1000 * tck_ps);
    endfunction : dltc_round_spd

    // Other parameters: ceiling(ps/tck)
    function automatic int dltc_round_up(input int ps, input int tck_ps);
        dltc_round_up = (ps + tck_ps - 1) / tck_ps;
    endfunction : dltc_round_up

endpackage : dltc_pkg

// >>> dltc_ctrl.sv
// Host sequencer for termination, write leveling, gear-down entry and refresh timing
//
// Contract
// - Hold termination high at least 4 cycles, or 5 in two-cycle preamble.
// - First rising strobe edge at least 40 cycles after leveling mode write.
// - Start driving strobes at least 25 cycles after leveling mode write.
// - Sample leveling feedback no sooner than 9.5 ns after the strobe edge.
// - Wait the reset-exit interval after clock enable high before gear-down write.
// - Allow the self-refresh-exit interval from clock enable high to gear-down.
// - Sync pulse at least mode-update delay plus 4 cycles after gear-down write.
// - Wait mode-update delay after sync pulse before the first command.
// - Refresh time grows by parity latency with parity on and loop off.
// - Select-to-command latency at least max(3 cycles, 3.748 ns per period).
// - Program clock counts obtained by the defined rounding of ns over period.
// - Convert ps to clocks: divide by period, add 0.974, truncate.
// - Below 1600 transfers use the timing set of the 1600 grade.
`timescale 1ns/10ps
`include "dltc_regs.svh"

module dltc_ctrl
    import dltc_pkg::*;
#(
    parameter int DATA_RATE = 1600                          // Transfers per second per pin, M
) (
    input  wire logic        mclk,                          // System clock 100 MHz
    input  wire logic        rst,                           // Async reset, active high
    input  wire logic        ce,                            // Clock enable, freezes all state
    input  wire logic        wb_cyc_i,                      // Wishbone cycle
    input  wire logic        wb_stb_i,                      // Wishbone strobe
    input  wire logic        wb_we_i,                       // Wishbone write enable
    input  wire logic [4:0]  wb_adr_i,                      // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,                      // Wishbone byte selects
    input  wire logic [31:0] wb_dat_i,                      // Wishbone write data
    output logic      [31:0] wb_dat_o,                      // Wishbone read data
    output logic             wb_ack_o,                      // Wishbone acknowledge
    output logic             ck_o,                          // Link clock, mclk divided by 2
    output logic             cke_o,                         // Memory clock enable
    output logic             cs_n_o,                        // Chip select, active low
    output logic      [2:0]  cmd_o,                         // Command code on the link
    output logic             term_o,                        // Termination control
    output logic             dqs_o,                         // Strobe output level
    output logic             dqs_oe_o,                      // Strobe output enable
    input  wire logic        dq_i                           // Leveling feedback from the device
);

    // ********************
    // Derived timing
    // ********************
    localparam int EFF_RATE = (DATA_RATE < `DLTC_SLOW_RATE) ? `DLTC_SLOW_RATE : DATA_RATE;
    localparam int CK_PS    = 2 * `DLTC_MCLK_PS;
    localparam int CAL_RAW  = dltc_round_spd(`DLTC_SEL_CMD_PS, CK_PS);
    localparam int CAL_INT  = (CAL_RAW > `DLTC_SEL_CMD_MIN) ? CAL_RAW : `DLTC_SEL_CMD_MIN;
    localparam logic [15:0] CAL_CK = 16'(CAL_INT);
    // Feedback wait plus three sync stages (two link cycles)
    localparam logic [15:0] WLO_CK = 16'(dltc_round_up(`DLTC_LEVEL_FEEDBACK_PS, CK_PS) + 2);

    // ********************
    // Register file
    // ********************
    logic [31:0] cfg0_ff, nxt_cfg0;     // [7:0] mode update, [15:8] parity lat, [31:16] refresh
    logic [31:0] cfg1_ff, nxt_cfg1;     // [15:0] reset exit, flags above
    logic [31:0] cfg2_ff, nxt_cfg2;     // [15:0] self-refresh exit
    logic [31:0] rdat_ff, nxt_rdat;
    logic        ack_ff,  nxt_ack;
    logic [3:0]  go_ff,   nxt_go;
    logic        bus_req;
    logic [31:0] status;

    dltc_state_t st_ff, nxt_st;
    logic [15:0] cnt_ff, nxt_cnt;
    logic        ck_ff, nxt_ck;
    logic        cke_ff, nxt_cke;
    logic        cs_n_ff, nxt_cs_n;
    dltc_cmd_t   cmd_ff, nxt_cmd;
    logic        term_ff, nxt_term;
    logic        dqs_ff, nxt_dqs;
    logic        dqs_oe_ff, nxt_dqs_oe;
    logic        dq_s1_ff, dq_s2_ff, dq_s3_ff, dq_val_ff, nxt_dq_val;
    logic        gear_done_ff, nxt_gear_done;
    logic        wl_done_ff, nxt_wl_done;
    logic        wl_fb_ff, nxt_wl_fb;

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = dat[8*i +: 8];
            end
        end
        merge = res;
    endfunction : merge

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign status  = {23'h0, st_ff, dq_val_ff, wl_fb_ff, wl_done_ff, gear_done_ff,
                      (st_ff != DLTC_IDLE) | (|go_ff)};

    always_comb begin
        nxt_cfg0 = cfg0_ff;
        nxt_cfg1 = cfg1_ff;
        nxt_cfg2 = cfg2_ff;
        nxt_rdat = rdat_ff;
        nxt_ack  = 1'b0;
        nxt_go   = 4'h0;
        if (bus_req) begin
            nxt_ack = 1'b1;
            if (wb_we_i) begin
                case (wb_adr_i)
                    `DLTC_OFS_CTRL: begin
                        nxt_go = wb_sel_i[0] ? wb_dat_i[3:0] : 4'h0;
                    end
                    `DLTC_OFS_CFG0: nxt_cfg0 = merge(cfg0_ff, wb_dat_i, wb_sel_i);
                    `DLTC_OFS_CFG1: nxt_cfg1 = merge(cfg1_ff, wb_dat_i, wb_sel_i);
                    `DLTC_OFS_CFG2: nxt_cfg2 = merge(cfg2_ff, wb_dat_i, wb_sel_i);
                    default: ;
                endcase
            end else begin
                case (wb_adr_i)
                    `DLTC_OFS_CFG0:   nxt_rdat = cfg0_ff;
                    `DLTC_OFS_CFG1:   nxt_rdat = {13'h0, cfg1_ff[18:0]};
                    `DLTC_OFS_CFG2:   nxt_rdat = {16'h0, cfg2_ff[15:0]};
                    `DLTC_OFS_STATUS: nxt_rdat = status;
                    default:          nxt_rdat = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg0_ff <= `DLTC_CFG0_RST;
            cfg1_ff <= `DLTC_CFG1_RST;
            cfg2_ff <= `DLTC_CFG2_RST;
            rdat_ff <= 32'h0;
            ack_ff  <= 1'b0;
            go_ff   <= 4'h0;
        end else if (ce) begin
            cfg0_ff <= nxt_cfg0;
            cfg1_ff <= nxt_cfg1;
            cfg2_ff <= nxt_cfg2;
            rdat_ff <= nxt_rdat;
            ack_ff  <= nxt_ack;
            go_ff   <= (go_ff & ((ck_ff && st_ff == DLTC_IDLE) ? go_ff - 4'h1 : 4'hF)) | nxt_go;
        end
    end

    // ********************
    // Link sequencer, one step per link clock cycle
    // ********************
    logic        step;
    logic        last;
    logic [15:0] mod_ck;
    logic [15:0] rfc_ck;
    logic [15:0] exit_ck;

    assign step    = ck_ff;
    assign last    = (cnt_ff == 16'h0);
    assign mod_ck  = {8'h0, cfg0_ff[7:0]};
    assign rfc_ck  = cfg0_ff[31:16] + ((cfg1_ff[`DLTC_CFG1_PAR_EN] & cfg1_ff[`DLTC_CFG1_DLL_OFF])
                     ? {8'h0, cfg0_ff[15:8]} : 16'h0);
    assign exit_ck = (cfg1_ff[15:0] > cfg2_ff[15:0]) ? cfg1_ff[15:0] : cfg2_ff[15:0];

    always_comb begin
        nxt_ck        = ~ck_ff;
        nxt_st        = st_ff;
        nxt_cnt       = cnt_ff;
        nxt_cke       = cke_ff;
        nxt_cs_n      = cs_n_ff;
        nxt_cmd       = cmd_ff;
        nxt_term      = term_ff;
        nxt_dqs       = dqs_ff;
        nxt_dqs_oe    = dqs_oe_ff;
        nxt_gear_done = gear_done_ff;
        nxt_wl_done   = wl_done_ff;
        nxt_wl_fb     = wl_fb_ff;
        nxt_dq_val    = (dq_s2_ff == dq_s3_ff) ? dq_s3_ff : dq_val_ff;
        if (step) begin
            nxt_cmd = DLTC_CMD_NOP;
            nxt_cnt = last ? 16'h0 : cnt_ff - 16'h1;
            case (st_ff)
                DLTC_IDLE: begin
                    nxt_cs_n = 1'b1;
                    if (go_ff[`DLTC_CTRL_GEAR]) begin
                        nxt_cke       = 1'b1;
                        nxt_gear_done = 1'b0;
                        nxt_cnt       = exit_ck;
                        nxt_st        = DLTC_RST;
                    end else if (go_ff[`DLTC_CTRL_LEVEL]) begin
                        nxt_cmd     = DLTC_CMD_MRS;
                        nxt_wl_done = 1'b0;
                        nxt_cnt     = `DLTC_LEVEL_STROBE_EN - 16'h1;
                        nxt_st      = DLTC_WENW;
                    end else if (go_ff[`DLTC_CTRL_TERM]) begin
                        nxt_term = 1'b1;
                        nxt_cnt  = (cfg1_ff[`DLTC_CFG1_PRE2] ? `DLTC_TERM_HIGH_MIN_LONG
                                   : `DLTC_TERM_HIGH_MIN_SHORT) - 16'h1;
                        nxt_st   = DLTC_TERM;
                    end else if (go_ff[`DLTC_CTRL_REFRESH]) begin
                        nxt_cmd = DLTC_CMD_REF;
                        nxt_cnt = rfc_ck - 16'h1;
                        nxt_st  = DLTC_REF;
                    end
                end
                DLTC_RST: begin
                    if (last) begin
                        nxt_cmd = DLTC_CMD_MRS;
                        nxt_cnt = mod_ck + `DLTC_SYNC_EXTRA - `DLTC_SYNC_SETUP - 16'h1;
                        nxt_st  = DLTC_GSYNW;
                    end
                end
                DLTC_GSYNW: begin
                    if (last) begin
                        nxt_cnt = `DLTC_SYNC_SETUP - 16'h1;
                        nxt_st  = DLTC_GSET;
                    end
                end
                DLTC_GSET: begin
                    if (last) begin
                        nxt_cmd = DLTC_CMD_SYNC;
                        nxt_cnt = `DLTC_SYNC_HOLD - 16'h1;
                        nxt_st  = DLTC_GHOLD;
                    end
                end
                DLTC_GHOLD: begin
                    if (last) begin
                        nxt_cnt = mod_ck - `DLTC_SYNC_HOLD - CAL_CK;
                        nxt_st  = DLTC_GCMDW;
                    end
                end
                DLTC_GCMDW: begin
                    if (last) begin
                        nxt_cs_n = 1'b0;
                        nxt_cnt  = CAL_CK - 16'h1;
                        nxt_st   = DLTC_GCAL;
                    end
                end
                DLTC_GCAL: begin
                    if (last) begin
                        nxt_cmd       = DLTC_CMD_VALID;
                        nxt_gear_done = 1'b1;
                        nxt_st        = DLTC_IDLE;
                    end
                end
                DLTC_WENW: begin
                    if (last) begin
                        nxt_dqs_oe = 1'b1;
                        nxt_dqs    = 1'b0;
                        nxt_cnt    = `DLTC_LEVEL_FIRST_STROBE - `DLTC_LEVEL_STROBE_EN
                                     - 16'h1;
                        nxt_st     = DLTC_WEDGE;
                    end
                end
                DLTC_WEDGE: begin
                    if (last) begin
                        nxt_dqs = 1'b1;
                        nxt_cnt = WLO_CK - 16'h1;
                        nxt_st  = DLTC_WSAMP;
                    end
                end
                DLTC_WSAMP: begin
                    if (last) begin
                        nxt_wl_fb   = dq_val_ff;
                        nxt_wl_done = 1'b1;
                        nxt_dqs     = 1'b0;
                        nxt_dqs_oe  = 1'b0;
                        nxt_st      = DLTC_IDLE;
                    end
                end
                DLTC_TERM: begin
                    if (last) begin
                        nxt_term = 1'b0;
                        nxt_st   = DLTC_IDLE;
                    end
                end
                DLTC_REF: begin
                    if (last) begin
                        nxt_st = DLTC_IDLE;
                    end
                end
                default: nxt_st = DLTC_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff        <= DLTC_IDLE;
            cnt_ff       <= 16'h0;
            ck_ff        <= 1'b0;
            cke_ff       <= 1'b0;
            cs_n_ff      <= 1'b1;
            cmd_ff       <= DLTC_CMD_NOP;
            term_ff      <= 1'b0;
            dqs_ff       <= 1'b0;
            dqs_oe_ff    <= 1'b0;
            dq_s1_ff     <= 1'b0;
            dq_s2_ff     <= 1'b0;
            dq_s3_ff     <= 1'b0;
            dq_val_ff    <= 1'b0;
            gear_done_ff <= 1'b0;
            wl_done_ff   <= 1'b0;
            wl_fb_ff     <= 1'b0;
        end else if (ce) begin
            st_ff        <= nxt_st;
            cnt_ff       <= nxt_cnt;
            ck_ff        <= nxt_ck;
            cke_ff       <= nxt_cke;
            cs_n_ff      <= nxt_cs_n;
            cmd_ff       <= nxt_cmd;
            term_ff      <= nxt_term;
            dqs_ff       <= nxt_dqs;
            dqs_oe_ff    <= nxt_dqs_oe;
            dq_s1_ff     <= dq_i;
            dq_s2_ff     <= dq_s1_ff;
            dq_s3_ff     <= dq_s2_ff;
            dq_val_ff    <= nxt_dq_val;
            gear_done_ff <= nxt_gear_done;
            wl_done_ff   <= nxt_wl_done;
            wl_fb_ff     <= nxt_wl_fb;
        end
    end

    // ********************
    // Outputs
    // ********************
    assign wb_dat_o = rdat_ff;
    assign wb_ack_o = ack_ff;
    assign ck_o     = ck_ff;
    assign cke_o    = cke_ff;
    assign cs_n_o   = cs_n_ff;
    assign cmd_o    = cmd_ff;
    assign term_o   = term_ff;
    assign dqs_o    = dqs_ff;
    assign dqs_oe_o = dqs_oe_ff;

endmodule : dltc_ctrl

// >>> dltc_ctrl_checker.sv
// Pin-timing assertions for the leveling and gear-down sequencer
`timescale 1ns/10ps
module dltc_ctrl_checker
    import dltc_pkg::*;
#(
    parameter int DATA_RATE = 1600     // Same as design
) (
    input wire logic       mclk,       // Clock
    input wire logic       rst,        // Reset
    input wire logic       wb_cyc_i,   // Bus cycle
    input wire logic       wb_stb_i,   // Bus strobe
    input wire logic       wb_ack_o,   // Bus ack
    input wire logic       cke_o,      // Clock enable
    input wire logic       cs_n_o,     // Select
    input wire logic [2:0] cmd_o,      // Command
    input wire logic       term_o,     // Termination
    input wire logic       dqs_o,      // Strobe
    input wire logic       dqs_oe_o    // Strobe enable
);
    // ********************
    // Cycle counters
    // ********************
    logic [15:0] mrs_ago_ff;
    logic [15:0] sync_ago_ff;
    logic [15:0] cs_low_ff;

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = v + {15'h0000, v != 16'hFFFF};
    endfunction : sat_inc

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mrs_ago_ff  <= 16'h0000;
            sync_ago_ff <= 16'h0000;
            cs_low_ff   <= 16'h0000;
        end else begin
            mrs_ago_ff  <= (cmd_o == DLTC_CMD_MRS) ? 16'h0000 : sat_inc(mrs_ago_ff);
            sync_ago_ff <= (cmd_o == DLTC_CMD_SYNC) ? 16'h0000 : sat_inc(sync_ago_ff);
            cs_low_ff   <= cs_n_o ? 16'h0000 : sat_inc(cs_low_ff);
        end
    end

    // ********************
    // Properties
    // ********************
    default clocking dltc_cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing");
    property p_term; $rose(term_o) |-> term_o [*8] ##[1:3] !term_o; endproperty
    a_term: assert property (p_term) else $error("term width");
    property p_lvl_en; $rose(dqs_oe_o) |-> mrs_ago_ff >= 16'h0030; endproperty
    a_lvl_en: assert property (p_lvl_en) else $error("strobe drive early");
    property p_lvl_edge; $rose(dqs_o) && dqs_oe_o |-> mrs_ago_ff >= 16'h004E; endproperty
    a_lvl_edge: assert property (p_lvl_edge) else $error("strobe edge early");
    property p_fb; $rose(dqs_o) && dqs_oe_o |=> dqs_oe_o [*2] ##[1:20] !dqs_oe_o; endproperty
    a_fb: assert property (p_fb) else $error("feedback wait");
    property p_cke; $rose(cke_o) |-> (cmd_o == DLTC_CMD_NOP) [*2]; endproperty
    a_cke: assert property (p_cke) else $error("mode write after cke early");
    property p_sync; $rose(cmd_o == DLTC_CMD_SYNC) |-> mrs_ago_ff >= 16'h0010; endproperty
    a_sync: assert property (p_sync) else $error("sync early");
    property p_hold; $rose(cmd_o == DLTC_CMD_SYNC) |-> $stable(cs_n_o) [*6]; endproperty
    a_hold: assert property (p_hold) else $error("select moved at sync");
    property p_first; $rose(cmd_o == DLTC_CMD_VALID) |-> sync_ago_ff >= 16'h0008; endproperty
    a_first: assert property (p_first) else $error("first command early");
    property p_cal; $rose(cmd_o == DLTC_CMD_VALID) |-> cs_low_ff >= 16'h0006; endproperty
    a_cal: assert property (p_cal) else $error("select latency short");

    c_term: cover property ($rose(term_o));
    c_edge: cover property ($rose(dqs_o) && dqs_oe_o);
    c_first: cover property ($rose(cmd_o == DLTC_CMD_VALID));
endmodule : dltc_ctrl_checker

bind dltc_ctrl dltc_ctrl_checker #(.DATA_RATE(DATA_RATE)) u_dltc_ctrl_checker (
    .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .cke_o(cke_o), .cs_n_o(cs_n_o), .cmd_o(cmd_o), .term_o(term_o), .dqs_o(dqs_o),
    .dqs_oe_o(dqs_oe_o)
);

// >>> dltc_dev_model.sv
// Device model answering leveling strobes with clock feedback
`timescale 1ns/10ps
module dltc_dev_model (
    input  wire logic dqs,     // Strobe
    input  wire logic dqs_oe,  // Strobe enable
    input  wire logic fb,      // Level to report
    output logic      dq       // Feedback
);
    // Internal write start after write latency: full burst or on-the-fly chop, fixed chop
    localparam int WR_START_FULL = 4;
    localparam int WR_START_CHOP = 2;
    initial dq = 1'b1;
    // Latest allowed arrival, inverse level before it
    always @(posedge dqs) begin
        if (dqs_oe === 1'b1) begin
            dq = ~fb;
            #9.5 dq = fb;
        end
    end
    always @(negedge dqs_oe) dq = ~fb;
endmodule : dltc_dev_model

// >>> test_dltc_ctrl.sv
// Self-checking bench for the leveling and gear-down sequencer
`timescale 1ns/10ps
`include "dltc_regs.svh"
module test_dltc_ctrl
    import dltc_pkg::*;
;
    logic        mclk, rst, ce, cyc, stb, we, fb;
    logic [4:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, rd_dat, wb_dat_o;
    logic        wb_ack_o, ck_o, cke_o, cs_n_o, term_o, dqs_o, dqs_oe_o, dq_i, tp, kp, ck_hold;
    logic [2:0]  cmd_o, cp;
    logic [15:0] rx, sx;
    logic [7:0]  mod;
    logic [31:0] q_exp[$], q_msk[$], q_ev[$];
    int          err_total = 0, n_compared = 0, seed = 32'h1431;
    int          cyc_n = 0, t_cke = 0, t_ref = 0, t_hi = 0, t_sync = 0, t_mrs = 0;

    dltc_ctrl #(.DATA_RATE(1600)) u_dltc_ctrl (
        .mclk(mclk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ck_o(ck_o), .cke_o(cke_o), .cs_n_o(cs_n_o), .cmd_o(cmd_o), .term_o(term_o),
        .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o), .dq_i(dq_i)
    );
    dltc_dev_model u_dltc_dev_model (.dqs(dqs_o), .dqs_oe(dqs_oe_o), .fb(fb), .dq(dq_i));

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    // ********************
    // Tasks
    // ********************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge mclk);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
        @(posedge mclk iff (wb_ack_o === 1'b1));
        rd_dat = wb_dat_o;
        {cyc, stb} <= 2'b00;
    endtask : wb

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        q_exp.push_back(e);
        q_msk.push_back(m);
        wb(1'b0, a, 4'hF, 32'h0);
    endtask : rd

    task automatic wait_idle;
        repeat (4) @(posedge mclk);
        do rd(`DLTC_OFS_STATUS, 32'h0, 32'h0); while (rd_dat[0] !== 1'b0);
    endtask : wait_idle

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // ********************
    // Monitor
    // ********************
    always @(posedge mclk) begin
        cyc_n = cyc_n + 1;
        if (wb_ack_o === 1'b1 && we === 1'b0) begin
            if (q_msk[0] != 32'h0) chk("read data", wb_dat_o & q_msk[0], q_exp[0]);
            void'(q_msk.pop_front());
            void'(q_exp.pop_front());
        end
        if (term_o === 1'b1 && tp !== 1'b1) t_hi = cyc_n;
        if (term_o !== 1'b1 && tp === 1'b1) chk("term high", cyc_n - t_hi, q_ev.pop_front());
        if (cke_o === 1'b1 && kp !== 1'b1) t_cke = cyc_n;
        if (cmd_o !== cp) begin
            case (cmd_o)
                DLTC_CMD_MRS: begin
                    if (t_cke != 0) chk("cke gap", 32'(cyc_n - t_cke >= q_ev.pop_front()), 1);
                    t_cke = 0;
                    t_mrs = cyc_n;
                end
                DLTC_CMD_SYNC: begin
                    chk("sync gap", 32'(cyc_n - t_mrs >= q_ev.pop_front()), 32'h1);
                    t_sync = cyc_n;
                end
                DLTC_CMD_VALID: chk("first gap", 32'(cyc_n - t_sync >= q_ev.pop_front()), 1);
                DLTC_CMD_REF: t_ref = cyc_n;
                default: ;
            endcase
        end
        tp = term_o;
        kp = cke_o;
        cp = cmd_o;
    end

    initial begin
        #200000;
        err_total++;
        $display("watchdog expired");
        give_verdict();
    end

    // ********************
    // Tests
    // ********************
    initial begin
        {cyc, stb, we, adr, sel, dat} = '0;
        {ce, fb, rst} = 3'b101;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rd(`DLTC_OFS_CTRL, 32'h0, 32'hFFFF_FFFF);
        rd(`DLTC_OFS_CFG0, `DLTC_CFG0_RST, 32'hFFFF_FFFF);
        rd(`DLTC_OFS_CFG1, `DLTC_CFG1_RST, 32'hFFFF_FFFF);
        rd(`DLTC_OFS_CFG2, `DLTC_CFG2_RST, 32'hFFFF_FFFF);
        wb(1'b1, 5'h14, 4'hF, $random(seed));
        rd(5'h14, 32'h0, 32'hFFFF_FFFF);
        wb(1'b1, `DLTC_OFS_CFG2, 4'h1, 32'hFFFF_FFAB);
        rd(`DLTC_OFS_CFG2, 32'h0000_01AB, 32'hFFFF_FFFF);
        $display("test registers done");
        q_ev = {32'h8, 32'h8, 32'hA};
        wb(1'b1, `DLTC_OFS_CTRL, 4'h1, 32'h4);
        repeat (4) @(posedge mclk);
        wb(1'b1, `DLTC_OFS_CTRL, 4'h1, 32'h4);
        wait_idle();
        wb(1'b1, `DLTC_OFS_CFG1, 4'h4, 32'h0001_0000);
        wb(1'b1, `DLTC_OFS_CTRL, 4'h1, 32'h4);
        wait_idle();
        $display("test term done");
        rx = $random(seed);
        fb <= rx[0];
        wb(1'b1, `DLTC_OFS_CTRL, 4'h1, 32'h2);
        wait_idle();
        rd(`DLTC_OFS_STATUS, {28'h0, rx[0], 3'b100}, 32'hC);
        $display("test leveling done");
        rx = 16'h3 + 16'($random(seed) & 7);
        sx = 16'h3 + 16'($random(seed) & 7);
        mod = 8'h5 + 8'($random(seed) & 3);
        wb(1'b1, `DLTC_OFS_CFG1, 4'hF, {16'h0, rx});
        wb(1'b1, `DLTC_OFS_CFG2, 4'hF, {16'h0, sx});
        wb(1'b1, `DLTC_OFS_CFG0, 4'hF, {16'hA, 8'h8, mod});
        q_ev.push_back(32'(2 * ((rx > sx ? rx : sx) + 1)));
        q_ev.push_back(32'(2 * (mod + 4)));
        q_ev.push_back(32'(2 * mod));
        wb(1'b1, `DLTC_OFS_CTRL, 4'h1, 32'h1);
        wait_idle();
        rd(`DLTC_OFS_STATUS, 32'h2, 32'h2);
        $display("test gear-down done");
        ce <= 1'b0;
        repeat (2) @(posedge mclk);
        ck_hold = ck_o;
        repeat (3) @(posedge mclk);
        chk("frozen link clock", ck_o, ck_hold);
        ce <= 1'b1;
        $display("test freeze done");
        wb(1'b1, `DLTC_OFS_CFG1, 4'hF, {16'h6, rx});
        wb(1'b1, `DLTC_OFS_CTRL, 4'h1, 32'h8);
        wait_idle();
        chk("refresh long", 32'(cyc_n - t_ref >= 36), 32'h1);
        wb(1'b1, `DLTC_OFS_CFG1, 4'hF, {16'h2, rx});
        wb(1'b1, `DLTC_OFS_CTRL, 4'h1, 32'h8);
        wait_idle();
        chk("refresh short", 32'(cyc_n - t_ref < 36), 32'h1);
        $display("test refresh done");
        repeat (2) @(posedge mclk);
        chk("pin events left", q_ev.size(), 32'h0);
        give_verdict();
    end
endmodule : test_dltc_ctrl
